// [hdl/pid_control_defs.svh]
// Offsets, field positions, reset values and timing counts of the PID block.
// Included by the block, its checks and its bench; definitions only.
`ifndef PID_CONTROL_DEFS_SVH
`define PID_CONTROL_DEFS_SVH

`define PID_ADDR_CTRL 4'h0
`define PID_ADDR_TSEL 4'h1
`define PID_ADDR_FSEL 4'h2
`define PID_ADDR_PERIOD 4'h3
`define PID_ADDR_GAIN 4'h4
`define PID_ADDR_KI 4'h5
`define PID_ADDR_TI 4'h6
`define PID_ADDR_KD 4'h7
`define PID_ADDR_TD 4'h8
`define PID_ADDR_BAND 4'h9
`define PID_ADDR_CONST 4'hA
`define PID_ADDR_RESULT 4'hB
`define PID_ADDR_STATUS 4'hC

`define PID_CTRL_EN_BIT 0
`define PID_CTRL_PROF_LSB 1
`define PID_CTRL_CH_LSB 3

`define PID_RST_PERIOD 16'h000A
`define PID_RST_GAIN 16'h0100
`define PID_FRAC_BITS 8
`define PID_PCT_FULL 16'h2710
`define PID_MS_PER_S 1000
`define PID_CLK_PERIOD_NS 100
`define PID_MS_NS 1000000
`define PID_DIV_STEPS 6'h28

`endif

// [hdl/pid_control_pkg.sv]
// Types shared by the PID block and its bench.
// Assumes pid_control_defs.svh sits beside it.
`default_nettype none
package pid_control_pkg;
    // Response profile as coded in the control register
    typedef enum logic [1:0] {
        PROF_SINGLE,
        PROF_SETPOINT,
        PROF_OVER,
        PROF_UNDER
    } profile_t;
    typedef enum logic [1:0] {S_IDLE, S_LOAD, S_DIV, S_CALC} state_t;
endpackage : pid_control_pkg
`default_nettype wire

// [hdl/pid_control_block.sv]
// Closed-loop PID engine with register port and two output channel muxes.
// Assumes a 10 MHz clock, synchronous inputs and eight source blocks that
// each present a signed 16-bit value with its own minimum and maximum.
//
// Contract
// - Output channel set to PID takes result
// - Target and feedback chosen from source blocks
// - Profile codes: single, setpoint, over, under
// - Recompute once every loop period in ms
// - Single: normalise both, result -100..100%
// - Setpoint: constant target bounded by feedback range
// - Over and under profiles clamp 0..100%
// - Error inside dead band counts as zero
// - Error, accumulation and PID sum per update
// - P gain is G; I gain G*Ki*T/Ti
// - D gain G*Kd*Td/T; all configurable
//
// Chosen here: the placing of the registers and the strobed register port.
`include "pid_control_defs.svh"
`default_nettype none
module pid_control_block
    import pid_control_pkg::*;
#(
    parameter int TICK_CYCLES = `PID_MS_NS / `PID_CLK_PERIOD_NS
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic [127:0] i_src_value,
    input wire logic [127:0] i_src_min,
    input wire logic [127:0] i_src_max,
    input wire logic [31:0] i_other_cmd,
    output logic [31:0] o_out_cmd,
    output logic [15:0] o_pid_result,
    output logic o_update
);
    logic [4:0] ctrl_reg, ctrl_next;
    logic [2:0] tsel_reg, tsel_next, fsel_reg, fsel_next;
    logic [15:0] period_reg, period_next, gain_reg, gain_next;
    logic [15:0] ki_reg, ki_next, ti_reg, ti_next, kd_reg, kd_next;
    logic [15:0] td_reg, td_next, band_reg, band_next, const_reg, const_next;
    logic [15:0] rdata_reg, rdata_next;
    logic busy;
    logic signed [15:0] result_reg, result_next;
    profile_t profile;
    logic enable;

    assign enable = ctrl_reg[`PID_CTRL_EN_BIT];
    assign profile = profile_t'(ctrl_reg[`PID_CTRL_PROF_LSB +: 2]);
    always_comb begin
        ctrl_next = ctrl_reg;
        tsel_next = tsel_reg;
        fsel_next = fsel_reg;
        period_next = period_reg;
        gain_next = gain_reg;
        ki_next = ki_reg;
        ti_next = ti_reg;
        kd_next = kd_reg;
        td_next = td_reg;
        band_next = band_reg;
        const_next = const_reg;
        rdata_next = 16'h0000;
        if (i_wr)
            case (i_addr)
                `PID_ADDR_CTRL: ctrl_next = i_wdata[4:0];
                `PID_ADDR_TSEL: tsel_next = i_wdata[2:0];
                `PID_ADDR_FSEL: fsel_next = i_wdata[2:0];
                `PID_ADDR_PERIOD: period_next = i_wdata;
                `PID_ADDR_GAIN: gain_next = i_wdata;
                `PID_ADDR_KI: ki_next = i_wdata;
                `PID_ADDR_TI: ti_next = i_wdata;
                `PID_ADDR_KD: kd_next = i_wdata;
                `PID_ADDR_TD: td_next = i_wdata;
                `PID_ADDR_BAND: band_next = i_wdata;
                `PID_ADDR_CONST: const_next = i_wdata;
                default: ;
            endcase
        if (i_rd)
            case (i_addr)
                `PID_ADDR_CTRL: rdata_next = {11'h000, ctrl_reg};
                `PID_ADDR_TSEL: rdata_next = {13'h0000, tsel_reg};
                `PID_ADDR_FSEL: rdata_next = {13'h0000, fsel_reg};
                `PID_ADDR_PERIOD: rdata_next = period_reg;
                `PID_ADDR_GAIN: rdata_next = gain_reg;
                `PID_ADDR_KI: rdata_next = ki_reg;
                `PID_ADDR_TI: rdata_next = ti_reg;
                `PID_ADDR_KD: rdata_next = kd_reg;
                `PID_ADDR_TD: rdata_next = td_reg;
                `PID_ADDR_BAND: rdata_next = band_reg;
                `PID_ADDR_CONST: rdata_next = const_reg;
                `PID_ADDR_RESULT: rdata_next = result_reg;
                `PID_ADDR_STATUS: rdata_next = {14'h0000, busy, enable};
                default: rdata_next = 16'h0000;
            endcase
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ctrl_reg <= 5'h00;
            tsel_reg <= 3'h0;
            fsel_reg <= 3'h0;
            period_reg <= `PID_RST_PERIOD;
            gain_reg <= `PID_RST_GAIN;
            ki_reg <= 16'h0000;
            ti_reg <= 16'h0000;
            kd_reg <= 16'h0000;
            td_reg <= 16'h0000;
            band_reg <= 16'h0000;
            const_reg <= 16'h0000;
            rdata_reg <= 16'h0000;
        end else begin
            ctrl_reg <= ctrl_next;
            tsel_reg <= tsel_next;
            fsel_reg <= fsel_next;
            period_reg <= period_next;
            gain_reg <= gain_next;
            ki_reg <= ki_next;
            ti_reg <= ti_next;
            kd_reg <= kd_next;
            td_reg <= td_next;
            band_reg <= band_next;
            const_reg <= const_next;
            rdata_reg <= rdata_next;
        end
    end
    // Engine: ms tick, loop timer, shared serial divider, PID update
    state_t state_reg, state_next;
    logic [13:0] tick_reg, tick_next;
    logic [15:0] ms_reg, ms_next;
    logic en_d_reg, en_d_next, upd_reg, upd_next;
    logic [1:0] job_reg, job_next;
    logic [5:0] step_reg, step_next;
    logic [39:0] dvd_reg, dvd_next;
    logic [16:0] rem_reg, rem_next;
    logic [15:0] dsr_reg, dsr_next;
    logic [15:0] tpct_reg, tpct_next, fpct_reg, fpct_next;
    logic [15:0] ig_reg, ig_next, dg_reg, dg_next;
    logic signed [31:0] acc_reg, acc_next, acc_sum;
    logic signed [16:0] prev_reg, prev_next;
    logic signed [15:0] v, lo, hi, tval, fval;
    logic [39:0] ld_dvd, qsh;
    logic [15:0] ld_dsr, quo16;
    logic [16:0] rem_sh;
    logic [31:0] gk;
    logic signed [16:0] err, raw_err;
    logic signed [17:0] derr;
    logic signed [51:0] sum, sum_sh;
    logic signed [15:0] lim_hi, lim_lo;
    assign busy = (state_reg != S_IDLE);
    // A shared divider trades ~160 cycles of latency per update for area;
    // a 1 ms period leaves ample slack.
    always_comb begin
        state_next = state_reg;
        tick_next = tick_reg;
        ms_next = ms_reg;
        en_d_next = enable;
        upd_next = 1'b0;
        job_next = job_reg;
        step_next = step_reg;
        dvd_next = dvd_reg;
        rem_next = rem_reg;
        dsr_next = dsr_reg;
        tpct_next = tpct_reg;
        fpct_next = fpct_reg;
        ig_next = ig_reg;
        dg_next = dg_reg;
        acc_next = acc_reg;
        prev_next = prev_reg;
        result_next = result_reg;
        tval = $signed(i_src_value[tsel_reg*16 +: 16]);
        fval = $signed(i_src_value[fsel_reg*16 +: 16]);
        // Setpoint profile pins the target to the constant on the feedback range
        v = (job_reg == 2'd0) ? ((profile == PROF_SETPOINT) ? $signed(const_reg) : tval)
                              : fval;
        lo = $signed(i_src_min[((job_reg == 2'd0 && profile != PROF_SETPOINT) ?
                                tsel_reg : fsel_reg)*16 +: 16]);
        hi = $signed(i_src_max[((job_reg == 2'd0 && profile != PROF_SETPOINT) ?
                                tsel_reg : fsel_reg)*16 +: 16]);
        if (v < lo) v = lo;
        if (v > hi) v = hi;
        gk = (job_reg == 2'd2) ? gain_reg * ki_reg : gain_reg * kd_reg;
        ld_dvd = 40'h00_0000_0000;
        ld_dsr = 16'h0000;
        case (job_reg)
            2'd0, 2'd1: begin
                // Percent in 0.01 % steps of the source's own span
                ld_dvd = 40'(17'(v - lo) * `PID_PCT_FULL);
                ld_dsr = (hi > lo) ? 16'(hi - lo) : 16'h0000;
            end
            2'd2: begin
                // T/Ti with both in ms: the 0.001 s scale cancels out
                ld_dvd = 40'(gk[31:`PID_FRAC_BITS] * period_reg);
                ld_dsr = ti_reg;
            end
            default: begin
                ld_dvd = 40'(gk[31:`PID_FRAC_BITS] * td_reg);
                ld_dsr = period_reg;
            end
        endcase
        rem_sh = {rem_reg[15:0], dvd_reg[39]};
        qsh = {dvd_reg[38:0], rem_sh >= {1'b0, dsr_reg}};
        // Zero divisor means zero span, Ti of zero or period of zero: term is zero
        quo16 = (dsr_reg == 16'h0000) ? 16'h0000 : (|qsh[39:16]) ? 16'hFFFF : qsh[15:0];
        raw_err = $signed({1'b0, tpct_reg}) - $signed({1'b0, fpct_reg});
        err = (raw_err < $signed({1'b0, band_reg}) && -raw_err < $signed({1'b0, band_reg})) ?
              17'sh00000 : raw_err;
        derr = 18'(err) - 18'(prev_reg);
        acc_sum = acc_reg + 32'(err);
        sum = 52'($signed({1'b0, gain_reg}) * err)
            + 52'($signed({1'b0, ig_reg}) * acc_sum)
            + 52'($signed({1'b0, dg_reg}) * derr);
        sum_sh = sum >>> `PID_FRAC_BITS;
        lim_hi = $signed(`PID_PCT_FULL);
        lim_lo = (profile == PROF_SINGLE) ? -$signed(`PID_PCT_FULL) : 16'sh0000;
        if (profile == PROF_OVER) sum_sh = -sum_sh;
        if (profile == PROF_OVER && !(fpct_reg > tpct_reg)) sum_sh = 52'sh0;
        if (profile == PROF_UNDER && !(fpct_reg < tpct_reg)) sum_sh = 52'sh0;
        if (enable && !en_d_reg) begin
            acc_next = 32'sh0;
            prev_next = 17'sh0;
            tick_next = 14'h0000;
            ms_next = 16'h0000;
        end else if (enable) begin
            if (tick_reg == 14'(TICK_CYCLES - 1)) begin
                tick_next = 14'h0000;
                ms_next = ms_reg + 16'h0001;
            end else begin
                tick_next = tick_reg + 14'h0001;
            end
        end
        case (state_reg)
            S_IDLE: begin
                // Zero period runs as 1 ms
                if (enable && en_d_reg && ms_reg >= ((period_reg == 16'h0000) ?
                                                    16'h0001 : period_reg)) begin
                    ms_next = 16'h0000;
                    job_next = 2'd0;
                    state_next = S_LOAD;
                end
            end
            S_LOAD: begin
                dvd_next = ld_dvd;
                dsr_next = ld_dsr;
                rem_next = 17'h00000;
                step_next = 6'h00;
                state_next = S_DIV;
            end
            S_DIV: begin
                rem_next = qsh[0] ? rem_sh - {1'b0, dsr_reg} : rem_sh;
                dvd_next = qsh;
                step_next = step_reg + 6'h01;
                if (step_reg == `PID_DIV_STEPS - 6'h01) begin
                    state_next = S_LOAD;
                    job_next = job_reg + 2'd1;
                    case (job_reg)
                        2'd0: tpct_next = quo16;
                        2'd1: fpct_next = quo16;
                        2'd2: ig_next = quo16;
                        default: begin
                            dg_next = quo16;
                            state_next = S_CALC;
                        end
                    endcase
                end
            end
            S_CALC: begin
                acc_next = acc_sum;
                prev_next = err;
                if (sum_sh > 52'(lim_hi)) result_next = lim_hi;
                else if (sum_sh < 52'(lim_lo)) result_next = lim_lo;
                else result_next = sum_sh[15:0];
                upd_next = 1'b1;
                state_next = S_IDLE;
            end
            default: state_next = S_IDLE;
        endcase
        if (!enable) state_next = S_IDLE;
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_reg <= S_IDLE;
            tick_reg <= 14'h0000;
            ms_reg <= 16'h0000;
            en_d_reg <= 1'b0;
            upd_reg <= 1'b0;
            job_reg <= 2'd0;
            step_reg <= 6'h00;
            dvd_reg <= 40'h00_0000_0000;
            rem_reg <= 17'h00000;
            dsr_reg <= 16'h0000;
            tpct_reg <= 16'h0000;
            fpct_reg <= 16'h0000;
            ig_reg <= 16'h0000;
            dg_reg <= 16'h0000;
            acc_reg <= 32'sh0;
            prev_reg <= 17'sh0;
            result_reg <= 16'sh0000;
        end else begin
            state_reg <= state_next;
            tick_reg <= tick_next;
            ms_reg <= ms_next;
            en_d_reg <= en_d_next;
            upd_reg <= upd_next;
            job_reg <= job_next;
            step_reg <= step_next;
            dvd_reg <= dvd_next;
            rem_reg <= rem_next;
            dsr_reg <= dsr_next;
            tpct_reg <= tpct_next;
            fpct_reg <= fpct_next;
            ig_reg <= ig_next;
            dg_reg <= dg_next;
            acc_reg <= acc_next;
            prev_reg <= prev_next;
            result_reg <= result_next;
        end
    end
    // Output channels: PID result or the channel's other command
    logic [31:0] out_reg, out_next;
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        always_comb begin
            out_next[ch*16 +: 16] = ctrl_reg[`PID_CTRL_CH_LSB + ch] ?
                result_reg : i_other_cmd[ch*16 +: 16];
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) out_reg <= 32'h0000_0000;
        else out_reg <= out_next;
    end
    assign o_rdata = rdata_reg;
    assign o_out_cmd = out_reg;
    assign o_pid_result = result_reg;
    assign o_update = upd_reg;
endmodule : pid_control_block
`default_nettype wire

// [verif/pid_control_assertions.sv]
// Port-level checks of the PID block, bound into every instance.
// Assumes the register map of pid_control_defs.svh; CTRL is mirrored from writes.
`include "pid_control_defs.svh"
`default_nettype none
module pid_control_assertions
    import pid_control_pkg::*;
#(
    parameter int TICK_CYCLES = 10000
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic [127:0] i_src_value,
    input wire logic [127:0] i_src_min,
    input wire logic [127:0] i_src_max,
    input wire logic [31:0] i_other_cmd,
    input wire logic [31:0] o_out_cmd,
    input wire logic [15:0] o_pid_result,
    input wire logic o_update
);
    logic [4:0] ctrl_reg;
    logic [4:0] ctrl_next;
    always_comb begin
        ctrl_next = ctrl_reg;
        if (i_wr && i_addr == `PID_ADDR_CTRL) begin
            ctrl_next = i_wdata[4:0];
        end
    end
    always_ff @(posedge i_clk) begin
        ctrl_reg <= i_rst_n ? ctrl_next : 5'h00;
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_rdata_one_cycle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data outside its cycle");
    a_update_pulse: assert property (o_update |=> !o_update)
        else $error("update longer than one cycle");
    a_result_holds: assert property (!o_update |-> $stable(o_pid_result))
        else $error("result moved without update");
    a_result_span: assert property ($signed(o_pid_result) <= 16'sh2710
        && $signed(o_pid_result) >= -16'sh2710) else $error("result out of span");
    a_clamp_positive: assert property (o_update && ctrl_reg[2:1] != PROF_SINGLE
        |-> !o_pid_result[15] && o_pid_result <= 16'h2710) else $error("result not clamped");
    a_ch0_mux: assert property ($past(i_rst_n) |-> o_out_cmd[15:0] ==
        ($past(ctrl_reg[3]) ? $past(o_pid_result) : $past(i_other_cmd[15:0])))
        else $error("channel 0 drive wrong");
    a_ch1_mux: assert property ($past(i_rst_n) |-> o_out_cmd[31:16] ==
        ($past(ctrl_reg[4]) ? $past(o_pid_result) : $past(i_other_cmd[31:16])))
        else $error("channel 1 drive wrong");
    a_idle_quiet: assert property (!ctrl_reg[0] && !$past(ctrl_reg[0]) |-> !o_update)
        else $error("update while inactive");
    a_read_back: assert property (i_wr && i_addr == `PID_ADDR_PERIOD ##1
        i_rd && i_addr == `PID_ADDR_PERIOD |=> o_rdata == $past(i_wdata, 2))
        else $error("period read back wrong");
    a_status_enable: assert property (i_rd && i_addr == `PID_ADDR_STATUS
        |=> o_rdata[0] == $past(ctrl_reg[0])) else $error("status enable wrong");
    c_over: cover property (o_update && ctrl_reg[2:1] == PROF_OVER);
    c_under: cover property (o_update && ctrl_reg[2:1] == PROF_UNDER);
    c_setpoint: cover property (o_update && ctrl_reg[2:1] == PROF_SETPOINT);
endmodule : pid_control_assertions
bind pid_control_block pid_control_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_src_value(i_src_value), .i_src_min(i_src_min),
    .i_src_max(i_src_max), .i_other_cmd(i_other_cmd), .o_out_cmd(o_out_cmd),
    .o_pid_result(o_pid_result), .o_update(o_update));
`default_nettype wire

// [verif/pid_control_block_tb.sv]
// Self-checking bench of the PID block: register port, profiles, tuning terms.
// Assumes every source spans 0 to 10000 raw, so raw values read as 0.01 % steps.
`include "pid_control_defs.svh"
`default_nettype none
module pid_control_block_tb
    import pid_control_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    // Short ms tick keeps the run small; period stays above the compute time
    localparam int TICK = 100;
    localparam int PER = 2;
    logic i_clk, i_rst_n, i_wr, i_rd;
    logic [3:0] i_addr;
    logic [15:0] i_wdata, o_rdata, o_pid_result;
    logic [127:0] i_src_value, i_src_min, i_src_max;
    logic [31:0] i_other_cmd, o_out_cmd;
    logic o_update;
    logic [1:0] ch_sel;
    int n_fail = 0;
    int check_count = 0;
    int k;
    pid_control_block #(.TICK_CYCLES(TICK)) dut_u (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_src_value(i_src_value), .i_src_min(i_src_min),
        .i_src_max(i_src_max), .i_other_cmd(i_other_cmd), .o_out_cmd(o_out_cmd),
        .o_pid_result(o_pid_result), .o_update(o_update));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    task wrap_up;
        if (n_fail == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    task cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
        i_wr <= w;
        i_rd <= r;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
    endtask : bus
    task wr(input logic [3:0] a, input logic [15:0] d);
        bus(1'b1, 1'b0, a, d);
        bus(1'b0, 1'b0, a, d);
    endtask : wr
    task rd(input logic [3:0] a, output logic [15:0] v);
        bus(1'b0, 1'b1, a, 16'h0000);
        i_rd <= 1'b0;
        #1 v = o_rdata;
        @(posedge i_clk);
    endtask : rd
    // Waits for the next update, checks it and the channel drive one cycle later
    task upd(input logic [15:0] exp, output int n);
        n = 0;
        do begin
            @(posedge i_clk);
            #1 n++;
        end while (o_update !== 1'b1 && n < 3000);
        cmp("update", 16'h0001, {15'h0000, o_update});
        cmp("result", exp, o_pid_result);
        @(posedge i_clk);
        #1 cmp("ch0 drive", ch_sel[0] ? exp : 16'h5A5A, o_out_cmd[15:0]);
        cmp("ch1 drive", ch_sel[1] ? exp : 16'hA5A5, o_out_cmd[31:16]);
        @(posedge i_clk);
    endtask : upd
    task run(input profile_t p, input int ts, input int fs, input logic [15:0] tv,
             input logic [15:0] fv, input logic [15:0] g, input logic [15:0] band,
             input logic [15:0] cst, input logic [1:0] ch, input logic [15:0] exp);
        i_src_value[16*ts +: 16] <= tv;
        wr(`PID_ADDR_CTRL, 16'h0000);
        i_src_value[16*fs +: 16] <= fv;
        wr(`PID_ADDR_TSEL, 16'(ts));
        wr(`PID_ADDR_FSEL, 16'(fs));
        wr(`PID_ADDR_GAIN, g);
        wr(`PID_ADDR_BAND, band);
        wr(`PID_ADDR_CONST, cst);
        ch_sel = ch;
        wr(`PID_ADDR_CTRL, {11'h000, ch, p, 1'b1});
        upd(exp, k);
    endtask : run
    task t_regs;
        logic [15:0] v;
        logic [15:0] rv [16];
        rv = '{16'h0000, 16'h0000, 16'h0000, `PID_RST_PERIOD, `PID_RST_GAIN, 16'h0000,
               16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
               16'h0000, 16'h0000, 16'h0000};
        for (int i = 0; i < 16; i++) begin
            rd(4'(i), v);
            cmp("reset value", rv[i], v);
        end
        wr(`PID_ADDR_RESULT, 16'h1234);
        rd(`PID_ADDR_RESULT, v);
        cmp("result write", 16'h0000, v);
        bus(1'b1, 1'b0, `PID_ADDR_PERIOD, 16'(PER));
        rd(`PID_ADDR_PERIOD, v);
        cmp("period", 16'(PER), v);
        // Integral factor set with zero integral time must give no integral term
        wr(`PID_ADDR_KI, 16'h0100);
        i_other_cmd <= 32'hA5A5_5A5A;
    endtask : t_regs
    task t_profiles;
        run(PROF_SINGLE, 0, 1, 16'h1388, 16'h09C4, 16'h0100, 0, 0, 1, 16'h09C4);
        run(PROF_SINGLE, 0, 1, 16'h1388, 16'h09C4, 16'h0100, 16'h0A28, 0, 1, 0);
        run(PROF_SINGLE, 0, 1, 16'h1388, 16'h09C4, 16'h0100, 16'h09C4, 0, 1, 16'h09C4);
        run(PROF_SINGLE, 5, 6, 0, 16'h2710, 16'h0100, 0, 0, 3, 16'hD8F0);
        run(PROF_SINGLE, 0, 1, 16'h2710, 0, 16'h0200, 0, 0, 1, 16'h2710);
        run(PROF_SETPOINT, 3, 1, 0, 16'h09C4, 16'h0100, 0, 16'h1770, 1, 16'h0DAC);
        run(PROF_SETPOINT, 3, 1, 0, 16'h1388, 16'h0100, 0, 0, 1, 0);
        run(PROF_OVER, 0, 1, 16'h09C4, 16'h1388, 16'h0100, 0, 0, 1, 16'h09C4);
        run(PROF_OVER, 0, 1, 16'h1388, 16'h09C4, 16'h0100, 0, 0, 1, 0);
        run(PROF_OVER, 0, 1, 0, 16'h2710, 16'h0200, 0, 0, 1, 16'h2710);
        run(PROF_UNDER, 0, 1, 16'h1388, 16'h09C4, 16'h0100, 0, 0, 1, 16'h09C4);
        run(PROF_UNDER, 0, 1, 16'h09C4, 16'h1388, 16'h0100, 0, 0, 1, 0);
        run(PROF_UNDER, 0, 1, 16'h1388, 16'h09C4, 16'h0100, 0, 0, 3, 16'h09C4);
    endtask : t_profiles
    task t_tuning;
        logic [15:0] v;
        wr(`PID_ADDR_TI, 16'(PER));
        run(PROF_SINGLE, 0, 1, 16'h1770, 16'h1388, 16'h0100, 0, 0, 1, 16'h07D0);
        upd(16'h0BB8, k);
        cmp("period", 16'(PER * TICK), 16'(k + 2));
        rd(`PID_ADDR_RESULT, v);
        cmp("result reg", 16'h0BB8, v);
        rd(`PID_ADDR_STATUS, v);
        cmp("status", 16'h0001, v & 16'h0001);
        run(PROF_SINGLE, 0, 1, 16'h1770, 16'h1388, 16'h0100, 0, 0, 1, 16'h07D0);
        wr(`PID_ADDR_KI, 16'h0000);
        wr(`PID_ADDR_KD, 16'h0100);
        wr(`PID_ADDR_TD, 16'(PER));
        run(PROF_SINGLE, 0, 1, 16'h1770, 16'h1388, 16'h0100, 0, 0, 1, 16'h07D0);
        upd(16'h03E8, k);
    endtask : t_tuning
    initial begin
        i_rst_n = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 4'h0;
        i_wdata = 16'h0000;
        i_src_value = 128'h0;
        i_src_min = 128'h0;
        i_src_max = {8{16'h2710}};
        i_other_cmd = 32'h0000_0000;
        ch_sel = 2'b00;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        t_regs();
        t_profiles();
        t_tuning();
        wrap_up();
    end
    // Whole run needs about 6600 cycles; a hang beyond four and a half times that fails
    initial begin
        #3000000;
        n_fail++;
        wrap_up();
    end
endmodule : pid_control_block_tb
`default_nettype wire
